// >>> rtl/pin_irq_ctrl.sv
// Request pin detector, pin configuration registers and vector priority selection.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pin_irq_ctrl
	import pin_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request pin and pad control
	input wire logic request_pin,
	output logic pull_enable,
	output logic pull_up,
	output logic wake_request,
	// Core side
	input wire logic stop_mode,
	input wire logic global_mask,
	input wire logic [NUM_VECTORS-1:0] source_flag,
	output logic pin_level_for_branch,
	output logic cpu_int_req,
	output logic [4:0] vector_number,
	output logic [15:0] vector_addr_high
);

	// ****************************************
	// State
	// ****************************************
	pin_cfg_t cfg;
	logic pin_request_flag;
	logic prev_asserted;
	logic pin_sync;
	logic [NUM_VECTORS-1:0] source_enable;
	vector_sel_t best;

	// ****************************************
	// Pin synchronizer
	// ****************************************
	pin_sync2 u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.async_in(request_pin),
		.sync_out(pin_sync)
	);

	// ****************************************
	// APB decode
	// ****************************************
	wire logic apb_access = psel & penable & pready;
	wire logic apb_write = apb_access & pwrite;
	wire logic hit_ctrl = (paddr == OFS_PIN_REQUEST_STATUS_CONTROL);
	wire logic hit_enable = (paddr == OFS_SOURCE_ENABLE);
	wire logic hit_vector = (paddr == OFS_VECTOR_STATUS);
	wire logic hit_any = hit_ctrl | hit_enable | hit_vector;
	wire logic wr_ctrl = apb_write & hit_ctrl;
	wire logic wr_enable = apb_write & hit_enable;

	// Control word as written, taken apart
	pin_cfg_t wr_cfg;
	assign wr_cfg.pull_device_disable = pwdata[BIT_PULL_DEVICE_DISABLE];
	assign wr_cfg.request_polarity_select = pwdata[BIT_REQUEST_POLARITY_SELECT];
	assign wr_cfg.request_pin_enable = pwdata[BIT_REQUEST_PIN_ENABLE];
	assign wr_cfg.pin_request_int_enable = pwdata[BIT_PIN_REQUEST_INT_ENABLE];
	assign wr_cfg.edge_level_mode_select = pwdata[BIT_EDGE_LEVEL_MODE_SELECT];

	// ****************************************
	// Detection terms
	// ****************************************
	// Asserted level follows polarity: 0 low/falling, 1 high/rising
	wire logic pin_asserted = cfg.request_polarity_select ? pin_sync : ~pin_sync;
	wire logic edge_event = cfg.request_pin_enable & pin_asserted & ~prev_asserted;
	wire logic level_hold = cfg.request_pin_enable & cfg.edge_level_mode_select & pin_asserted;
	wire logic enable_rise = wr_ctrl & wr_cfg.request_pin_enable & ~cfg.request_pin_enable;
	wire logic flag_set = edge_event | level_hold | enable_rise;
	wire logic flag_clear = wr_ctrl & pwdata[BIT_FLAG_ACK];
	// Set beats clear so an event in the ack cycle is kept
	wire logic next_flag = flag_set ? 1'b1 : (flag_clear ? 1'b0 : pin_request_flag);

	// Flag reaches the vector logic only through its local enable
	wire logic pin_request_out = pin_request_flag & cfg.pin_request_int_enable;

	// Merge own request into the source vector
	logic [NUM_VECTORS-1:0] pending;
	always_comb
	begin
		pending = source_flag & (source_enable | ALWAYS_ENABLED);
		pending[VEC_PIN_REQUEST] = pin_request_out;
	end

	// Lowest number wins; loop runs high to low so the last hit is the winner
	vector_sel_t next_best;
	always_comb
	begin
		next_best = '{pending: 1'b0, number: 5'h00, addr_high: VEC_TOP_ADDR};
		for (int i = NUM_VECTORS - 1; i >= 0; i--)
		begin
			if (pending[i])
			begin
				next_best.pending = 1'b1;
				next_best.number = 5'(i);
				next_best.addr_high = VEC_TOP_ADDR - {10'h000, 5'(i), 1'b0};
			end
		end
	end

	// Reset and software vectors are not maskable by the global mask
	wire logic unmaskable = pending[VEC_RESET] | pending[VEC_SOFTWARE];
	wire logic next_int_req = next_best.pending & (~global_mask | unmaskable);

	// Read mux
	logic [31:0] read_word;
	always_comb
	begin
		read_word = 32'h00000000;
		if (hit_ctrl)
		begin
			read_word[BIT_PULL_DEVICE_DISABLE] = cfg.pull_device_disable;
			read_word[BIT_REQUEST_POLARITY_SELECT] = cfg.request_polarity_select;
			read_word[BIT_REQUEST_PIN_ENABLE] = cfg.request_pin_enable;
			read_word[BIT_PIN_REQUEST_FLAG] = pin_request_flag;
			read_word[BIT_PIN_REQUEST_INT_ENABLE] = cfg.pin_request_int_enable;
			read_word[BIT_EDGE_LEVEL_MODE_SELECT] = cfg.edge_level_mode_select;
		end
		else if (hit_enable)
			read_word[NUM_VECTORS-1:0] = source_enable;
		else if (hit_vector)
			read_word[21:0] = {best.pending, best.number, best.addr_high};
	end

	// ****************************************
	// APB answer: one wait state, then ready
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit_any;
			prdata <= (psel & penable & ~pready & ~pwrite) ? read_word : 32'h00000000;
		end
	end

	// ****************************************
	// Configuration and flag
	// ****************************************
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cfg <= PIN_CFG_RESET;
			source_enable <= SOURCE_ENABLE_RESET;
			pin_request_flag <= 1'b0;
			prev_asserted <= 1'b1;
		end
		else
		begin
			if (wr_ctrl)
				cfg <= wr_cfg;
			if (wr_enable)
				source_enable <= pwdata[NUM_VECTORS-1:0];
			pin_request_flag <= next_flag;
			prev_asserted <= pin_asserted;
		end
	end

	// ****************************************
	// Outputs to pad and core: registered, except the clockless wake path
	// ****************************************
	// Pull only while enabled and not disabled; direction follows polarity
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			pull_enable <= 1'b0;
			pull_up <= 1'b1;
			pin_level_for_branch <= 1'b1;
			cpu_int_req <= 1'b0;
			best <= '{pending: 1'b0, number: 5'h00, addr_high: VEC_TOP_ADDR};
		end
		else
		begin
			pull_enable <= cfg.request_pin_enable & ~cfg.pull_device_disable;
			pull_up <= ~cfg.request_polarity_select;
			pin_level_for_branch <= cfg.request_pin_enable ? pin_sync : 1'b1;
			cpu_int_req <= next_int_req;
			best <= next_best;
		end
	end

	assign vector_number = best.number;
	assign vector_addr_high = best.addr_high;

	// Clockless wake path: stop mode halts clk_sys, so this cannot be a flop
	always_comb
	begin
		wake_request = stop_mode & cfg.request_pin_enable
			& (cfg.request_polarity_select ? request_pin : ~request_pin);
	end

	// ****************************************
	// Checks
	// ****************************************
	flag_edge_set_a: assert property (@(posedge clk_sys) disable iff (rst)
		edge_event |=> pin_request_flag)
		else $error("edge did not set request flag");

	level_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		(level_hold && flag_clear) |=> pin_request_flag)
		else $error("clear took effect while pin asserted in level mode");

	enable_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
		enable_rise |=> pin_request_flag && cfg.request_pin_enable)
		else $error("enabling the pin did not set the flag");

	pin_ignored_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!cfg.request_pin_enable && !enable_rise && !pin_request_flag) |=> !pin_request_flag)
		else $error("flag set while pin disabled");

	pull_state_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cfg.request_pin_enable && cfg.pull_device_disable) ##1 $stable(cfg) |-> !pull_enable)
		else $error("pull active although disabled");

	pull_dir_a: assert property (@(posedge clk_sys) disable iff (rst)
		##1 (pull_up == !$past(cfg.request_polarity_select)))
		else $error("pull direction does not match polarity");

	irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		(pin_request_flag && !cfg.pin_request_int_enable && source_flag == '0)
		|=> !cpu_int_req)
		else $error("request forwarded without local enable");

	mask_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
		(global_mask && !unmaskable) |=> !cpu_int_req)
		else $error("request issued while globally masked");

	vec_prio_a: assert property (@(posedge clk_sys) disable iff (rst)
		(pending[VEC_SOFTWARE] && !pending[VEC_RESET]) |=> vector_number == VEC_SOFTWARE)
		else $error("software vector lost priority");

	vec_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
		##1 (vector_addr_high == VEC_TOP_ADDR - {10'h000, vector_number, 1'b0}))
		else $error("vector address does not match number");

	apb_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("ready not a single pulse after one wait");

	// ****************************************
	// Pad, branch and wake checks
	// ****************************************
	pull_on_a: assert property (@(posedge clk_sys) disable iff (rst)
		(cfg.request_pin_enable && !cfg.pull_device_disable) |=> pull_enable)
		else $error("pull missing on enabled pin");

	pull_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!cfg.request_pin_enable |=> !pull_enable)
		else $error("pull active on disabled pin");

	branch_level_a: assert property (@(posedge clk_sys) disable iff (rst)
		cfg.request_pin_enable |=> (pin_level_for_branch == $past(pin_sync)))
		else $error("branch level does not follow pin");

	// Raw pin path has no flop, so it is checked in the same cycle
	wake_on_a: assert property (@(posedge clk_sys) disable iff (rst)
		(stop_mode && cfg.request_pin_enable && (request_pin == cfg.request_polarity_select))
		|-> wake_request)
		else $error("asserted pin did not wake the device");

	wake_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!stop_mode |-> !wake_request)
		else $error("wake raised outside stop mode");

	// ****************************************
	// Flag, synchronizer and request checks
	// ****************************************
	sync_delay_a: assert property (@(posedge clk_sys) disable iff (rst)
		##2 (pin_sync == $past(request_pin, 2)))
		else $error("pin not seen after two stages");

	ack_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
		(flag_clear && !flag_set) |=> !pin_request_flag)
		else $error("ack did not clear request flag");

	pin_forward_a: assert property (@(posedge clk_sys) disable iff (rst)
		(pin_request_flag && cfg.pin_request_int_enable && !global_mask) |=> cpu_int_req)
		else $error("enabled pin request not forwarded");

	vec_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
		(pending[VEC_PIN_REQUEST] && !pending[VEC_RESET] && !pending[VEC_SOFTWARE])
		|=> (vector_number == VEC_PIN_REQUEST))
		else $error("pin vector lost priority");

	// Error reply must never stand apart from the ready pulse
	err_with_ready_a: assert property (@(posedge clk_sys) disable iff (rst)
		pslverr |-> pready)
		else $error("error reply outside ready cycle");

endmodule : pin_irq_ctrl
`default_nettype wire

// >>> rtl/pin_irq_pkg.sv
// Constants, field layouts and carrier types of the request pin and vector block.
// Summary of operation
// - Pin acts as request input only while the pin enable bit is 1.
// - Clocked logic watches the enabled pin for edges only, or edges and levels.
// - In stop mode an enabled pin wakes the device through a clockless path.
// - A polarity bit picks which edge or edge plus level counts as asserted.
// - Polarity 0 means falling or low; polarity 1 means rising or high.
// - Software picks interrupt or mere flag setting for polling.
// - Enabled pin with pull disable 0 gets a pull matching the polarity.
// - Pull disable 1 turns the internal pull off for an external resistor.
// - The enabled pin's level is offered to the branch-on-pin-level instructions.
// - Enabling the pin as request input sets the request flag.
// - Edge detection sets the flag when the pin goes deasserted to asserted.
// - Edge-and-level mode holds the flag and ignores clears while pin stays asserted.
// - Each source sets its flag; a request goes on only with its local enable 1, except reset and software, which are always enabled.
// - With global mask 0 the CPU is asked to take the highest pending vector.
// - Each vector is two bytes: high byte at the even address, low byte next.
// - Lower vector number means higher priority: reset, software, pin, low voltage.
// - Vectors 0 to 28 at descending addresses; slots 29 to 31 unused.
package pin_irq_pkg;

	// ****************************************
	// Register map, APB byte addresses
	// ****************************************
	localparam logic [7:0] OFS_PIN_REQUEST_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_SOURCE_ENABLE = 8'h04;
	localparam logic [7:0] OFS_VECTOR_STATUS = 8'h08;

	// ****************************************
	// Control and status field positions
	// ****************************************
	localparam int BIT_PULL_DEVICE_DISABLE = 6;
	localparam int BIT_REQUEST_POLARITY_SELECT = 5;
	localparam int BIT_REQUEST_PIN_ENABLE = 4;
	localparam int BIT_PIN_REQUEST_FLAG = 3;
	localparam int BIT_FLAG_ACK = 2;
	localparam int BIT_PIN_REQUEST_INT_ENABLE = 1;
	localparam int BIT_EDGE_LEVEL_MODE_SELECT = 0;

	// ****************************************
	// Vector table
	// ****************************************
	localparam int NUM_VECTORS = 29;
	localparam logic [4:0] VEC_RESET = 5'h00;
	localparam logic [4:0] VEC_SOFTWARE = 5'h01;
	localparam logic [4:0] VEC_PIN_REQUEST = 5'h02;
	localparam logic [4:0] VEC_LOW_VOLTAGE = 5'h03;
	localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
	localparam logic [NUM_VECTORS-1:0] SOURCE_ENABLE_RESET = 29'h00000000;
	localparam logic [NUM_VECTORS-1:0] ALWAYS_ENABLED = 29'h00000003;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic pull_device_disable;
		logic request_polarity_select;
		logic request_pin_enable;
		logic pin_request_int_enable;
		logic edge_level_mode_select;
	} pin_cfg_t;

	localparam pin_cfg_t PIN_CFG_RESET = '{default: 1'b0};

	typedef struct packed {
		logic pending;
		logic [4:0] number;
		logic [15:0] addr_high;
	} vector_sel_t;

endpackage : pin_irq_pkg

// >>> rtl/pin_sync2.sv
// Two-stage synchronizer for the request pin.
`timescale 1ns/10ps
`default_nettype none
module pin_sync2
	import pin_irq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Data
	input wire logic async_in,
	output logic sync_out
);

	logic stage1;

	// First stage feeds only the second; reset to idle-high
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			stage1 <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : pin_sync2
`default_nettype wire

// >>> test/irq_source_model.sv
// External device model that drives the request pin.
`timescale 1ns/10ps
`default_nettype none
module irq_source_model
(
	// Clock
	input wire logic clk_sys,
	// Bench control
	input wire logic drive_en,
	input wire logic drive_val,
	// Pad control from the device
	input wire logic pull_enable,
	input wire logic pull_up,
	// Pin
	output logic pin
);
	logic wander = 1'b0;

	// Floating pin toggles so a stale level never looks valid
	always @(posedge clk_sys)
	begin
		wander <= ~wander;
	end

	// Driven, else pulled, else floating
	assign pin = drive_en ? drive_val : (pull_enable ? pull_up : wander);
endmodule : irq_source_model
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the request pin and vector block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin $display("[ERR] %s exp %0h got %0h", nm, ex, got); bad_count++; end end
module tb
	import pin_irq_pkg::*;
;
	typedef struct packed {logic [28:0] fl; logic [28:0] en; logic mk; logic rq; logic [4:0] num;} row_t;
	row_t rows [7] = '{
		'{29'h28, 29'h20, 1'b0, 1'b1, 5'd5},
		'{29'h28, 29'h28, 1'b0, 1'b1, 5'd3},
		'{29'h28, 29'h28, 1'b1, 1'b0, 5'd3},
		'{29'h2, 29'h0, 1'b1, 1'b1, 5'd1},
		'{29'h3, 29'h0, 1'b1, 1'b1, 5'd0},
		'{29'h10000000, 29'h10000000, 1'b0, 1'b1, 5'd28},
		'{29'h4, 29'h1FFFFFFF, 1'b0, 1'b0, 5'd0}};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd, prdata;
	logic stop_mode = 1'b0;
	logic global_mask = 1'b1;
	logic drv_en = 1'b1;
	logic drv_val = 1'b1;
	logic [NUM_VECTORS-1:0] source_flag = '0;
	logic pready, pslverr, err, pull_enable, pull_up, wake_request, request_pin;
	logic pin_level_for_branch, cpu_int_req;
	logic [4:0] vector_number;
	logic [15:0] vector_addr_high;
	int bad_count = 0;
	int check_count = 0;

	// Bus clock, 125 MHz
	always #4 clk_sys = ~clk_sys;

	pin_irq_ctrl dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.request_pin(request_pin), .pull_enable(pull_enable), .pull_up(pull_up),
		.wake_request(wake_request), .stop_mode(stop_mode), .global_mask(global_mask),
		.source_flag(source_flag), .pin_level_for_branch(pin_level_for_branch),
		.cpu_int_req(cpu_int_req), .vector_number(vector_number), .vector_addr_high(vector_addr_high));

	irq_source_model src_u (.clk_sys(clk_sys), .drive_en(drv_en), .drive_val(drv_val),
		.pull_enable(pull_enable), .pull_up(pull_up), .pin(request_pin));

	// Verdict and end of run
	task complete_run;
		$display("checks %0d errors %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_sys);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20)
		begin
			bad_count++;
			complete_run();
		end
	endtask : apb

	// Read the pin flag after the detector has settled
	task flag_is(input logic ex);
		tick(4);
		apb(1'b0, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h0);
		`CHK("pin_request_flag", ex, rd[BIT_PIN_REQUEST_FLAG])
	endtask : flag_is

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		tick(6);
		rst <= 1'b0;
		apb(1'b0, OFS_VECTOR_STATUS, 32'h0);
		`CHK("vector_status", {16'h0, VEC_TOP_ADDR}, rd)
		`CHK("pull_enable", 1'b0, pull_enable)
		`CHK("branch_level", 1'b1, pin_level_for_branch)
		// Source table: flags, enables and mask against the chosen vector
		foreach (rows[i])
		begin
			source_flag <= rows[i].fl;
			global_mask <= rows[i].mk;
			apb(1'b1, OFS_SOURCE_ENABLE, {3'b0, rows[i].en});
			tick(3);
			`CHK("cpu_int_req", rows[i].rq, cpu_int_req)
			`CHK("vector_number", rows[i].num, vector_number)
			`CHK("vector_addr", 16'hFFFE - 16'(2 * rows[i].num), vector_addr_high)
		end
		source_flag <= '0;
		global_mask <= 1'b0;
		apb(1'b1, 8'h0C, 32'hFF);
		`CHK("unmapped_err", 1'b1, err)
		// Enable falling mode: pull-up on, flag set by enabling
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h10);
		tick(2);
		`CHK("pull_up", 1'b1, pull_up)
		`CHK("pull_enable", 1'b1, pull_enable)
		flag_is(1'b1);
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h14);
		flag_is(1'b0);
		tick(6);
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h12);
		drv_en <= 1'b1;
		drv_val <= 1'b0;
		tick(6);
		`CHK("cpu_int_req", 1'b1, cpu_int_req)
		`CHK("vector_number", VEC_PIN_REQUEST, vector_number)
		`CHK("vector_addr", 16'hFFFA, vector_addr_high)
		`CHK("branch_level", 1'b0, pin_level_for_branch)
		stop_mode <= 1'b1;
		tick(1);
		`CHK("wake_request", 1'b1, wake_request)
		stop_mode <= 1'b0;
		// Edge mode: ack while still low clears
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h16);
		flag_is(1'b0);
		// Level mode: ack ignored while asserted
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h17);
		flag_is(1'b1);
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h17);
		flag_is(1'b1);
		drv_val <= 1'b1;
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h15);
		flag_is(1'b0);
		// Poll only: flag without request
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h10);
		drv_val <= 1'b0;
		flag_is(1'b1);
		`CHK("cpu_int_req", 1'b0, cpu_int_req)
		// Rising polarity, pull-down, then pull disabled
		drv_en <= 1'b0;
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h30);
		tick(2);
		`CHK("pull_up", 1'b0, pull_up)
		// Switching polarity on a pulled pin may look like an edge: ack once settled
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h34);
		flag_is(1'b0);
		drv_en <= 1'b1;
		drv_val <= 1'b1;
		flag_is(1'b1);
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h70);
		tick(2);
		`CHK("pull_enable", 1'b0, pull_enable)
		// Disabled pin ignored
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h24);
		drv_val <= 1'b0;
		tick(2);
		drv_val <= 1'b1;
		flag_is(1'b0);
		// Mid-run reset: configuration, flag and request all return to idle
		apb(1'b1, OFS_PIN_REQUEST_STATUS_CONTROL, 32'h10);
		source_flag <= 29'h8;
		tick(3);
		`CHK("cpu_int_req", 1'b1, cpu_int_req)
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(1);
		`CHK("pull_enable", 1'b0, pull_enable)
		`CHK("cpu_int_req", 1'b0, cpu_int_req)
		`CHK("vector_addr", VEC_TOP_ADDR, vector_addr_high)
		flag_is(1'b0);
		source_flag <= '0;
		complete_run();
	end
endmodule : tb
`default_nettype wire
